// file: core/tofr_regs.sv
// Function
// (R1) Stop-4 fine interval at 0x16, parity bit 23
// (R2) Stop-4 coarse count at 0x17, 16-bit count
// (R3) Stop-5 fine interval at 0x18, parity bit 23
// (R4) Stop-5 coarse count at 0x19, 16-bit count
// (R5) Stop-6 fine interval at 0x1A, parity bit 23
// (R6) First calibration at 0x1B, 23-bit unsigned
// (R7) Coarse bits 22:16 zero unless averaging mode
// (R8) All read-only, zero after reset, writes ignored
// (R9) Even parity over bits 22:0 on load
// (R10) Update only on completion, hold otherwise
`timescale 1ns/1ps
`include "tofr_params.svh"
module tofr_regs (
	input  wire logic                   mclk,
	input  wire logic                   rst,
	input  wire logic [5:0]             reg_addr,
	input  wire logic                   reg_rd,
	input  wire logic                   reg_wr,
	output logic [23:0]                 reg_rdata,
	output logic                        reg_rvalid,
	input  wire logic                   res_load,
	input  wire tofr_pkg::tofr_idx_t    res_sel,
	input  wire tofr_pkg::tofr_value_t  res_value,
	input  wire logic                   avg_mode
);

	tofr_mem_if           mif ();
	tofr_pkg::tofr_idx_t  rd_idx;
	logic                 rd_hit;
	tofr_pkg::tofr_kind_e load_kind;
	tofr_pkg::tofr_value_t load_value;
	tofr_pkg::tofr_word_t load_word;
	logic                 pend_reg;
	logic                 pend_hit_reg;
	logic [23:0]          reg_rdata_reg;
	logic                 reg_rvalid_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Address decode for the register port
	// Unmapped addresses fall to slot 0 with the hit flag low
	always_comb begin
		rd_idx = `TOFR_IDX_S4_FINE;
		rd_hit = 1'b1;
		if (reg_addr == `TOFR_ADDR_S4_FINE) begin
			rd_idx = `TOFR_IDX_S4_FINE; // see (R1)
		end else if (reg_addr == `TOFR_ADDR_S4_COARSE) begin
			rd_idx = `TOFR_IDX_S4_COARSE; // see (R2)
		end else if (reg_addr == `TOFR_ADDR_S5_FINE) begin
			rd_idx = `TOFR_IDX_S5_FINE; // see (R3)
		end else if (reg_addr == `TOFR_ADDR_S5_COARSE) begin
			rd_idx = `TOFR_IDX_S5_COARSE; // see (R4)
		end else if (reg_addr == `TOFR_ADDR_S6_FINE) begin
			rd_idx = `TOFR_IDX_S6_FINE; // see (R5)
		end else if (reg_addr == `TOFR_ADDR_CAL1) begin
			rd_idx = `TOFR_IDX_CAL1; // see (R6)
		end else begin
			rd_hit = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Kind of the slot being loaded
	always_comb begin
		if (res_sel == `TOFR_IDX_S4_COARSE) begin
			load_kind = tofr_pkg::TOFR_COARSE;
		end else if (res_sel == `TOFR_IDX_S5_COARSE) begin
			load_kind = tofr_pkg::TOFR_COARSE;
		end else begin
			load_kind = tofr_pkg::TOFR_FINE;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Build the stored word; extension bits only survive in averaging mode
	// Even parity, so a whole stored word always XORs to zero
	always_comb begin
		load_value = res_value;
		if (load_kind == tofr_pkg::TOFR_COARSE && !avg_mode) begin
			load_value[`TOFR_EXT_MSB:`TOFR_EXT_LSB] = `TOFR_EXT_ZERO; // see (R7)
		end
		load_word = {^load_value, load_value}; // see (R9)
	end

	// Only the measurement side writes; host writes have no path here
	assign mif.we    = res_load && (res_sel < 3'(`TOFR_NUM_REGS)); // see (R8), see (R10)
	assign mif.waddr = res_sel;
	assign mif.wdata = load_word;
	assign mif.re    = reg_rd && rd_hit;
	assign mif.raddr = rd_idx;

	tofr_mem u_mem (
		.mclk (mclk),
		.rst  (rst),
		.mif  (mif)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Read pipeline, stage one: remember a read is pending and whether it hit
	// Two register stages cost a cycle but keep every output on a flop
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pend_reg     <= 1'b0;
			pend_hit_reg <= 1'b0;
		end else begin
			pend_reg     <= reg_rd;
			pend_hit_reg <= reg_rd && rd_hit;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Stage two: output flops; unmapped reads answer zero
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			reg_rdata_reg  <= `TOFR_RESET_WORD;
			reg_rvalid_reg <= 1'b0;
		end else begin
			reg_rvalid_reg <= pend_reg;
			if (pend_reg) begin
				reg_rdata_reg <= pend_hit_reg ? mif.rdata : `TOFR_RESET_WORD;
			end
		end
	end

	assign reg_rdata  = reg_rdata_reg;
	assign reg_rvalid = reg_rvalid_reg;

	////////////////////////////////////////////////////////////////////////////////
	// All checks share the one clock and sleep through reset, since
	// reset clears the bank without a clock and nothing is owed then
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	AST_PARITY_EVEN: assert property (reg_rvalid |-> ^reg_rdata == 1'b0) // see (R9)
		else $error("read word has odd parity");
	AST_COARSE_EXT_ZERO: assert property (mif.we && (mif.waddr == 3'h1 || mif.waddr == 3'h3) && !avg_mode // see (R7)
		|-> mif.wdata[22:16] == 7'h00)
		else $error("coarse extension bits set outside averaging");
	AST_WRITE_IGNORED: assert property (reg_wr && !res_load |-> !mif.we) // see (R8)
		else $error("host write reached storage");
	AST_READ_LATENCY: assert property (reg_rd |-> ##2 reg_rvalid)
		else $error("read answer not two cycles later");
	AST_NO_SPURIOUS: assert property (!reg_rd |-> ##2 !reg_rvalid)
		else $error("answer without a read");
	AST_UNMAPPED_ZERO: assert property (reg_rd && !rd_hit |-> ##2 reg_rdata == 24'h000000)
		else $error("unmapped read not zero");
	AST_MAP_CAL1: assert property (reg_rd && reg_addr == 6'h1B |-> mif.re && mif.raddr == 3'h5) // see (R6)
		else $error("calibration address decoded wrong");
	AST_LOAD_READBACK: assert property (res_load && res_sel == 3'h0 // see (R1), see (R10)
		##1 reg_rd && reg_addr == 6'h16 && !res_load |-> ##2 reg_rdata[22:0] == $past(res_value, 3))
		else $error("stop-4 fine value not read back");
	AST_STOP5_READBACK: assert property (res_load && res_sel == 3'h2 // see (R3)
		##1 reg_rd && reg_addr == 6'h18 && !res_load |-> ##2 reg_rdata[22:0] == $past(res_value, 3))
		else $error("stop-5 fine value not read back");

	AST_STOP6_READBACK: assert property (res_load && res_sel == 3'h4 // see (R5)
		##1 reg_rd && reg_addr == 6'h1A && !res_load |-> ##2 reg_rdata[22:0] == $past(res_value, 3))
		else $error("stop-6 fine value not read back");

	////////////////////////////////////////////////////////////////////////////////
	// Each mapped address reaches its own slot; a wrong slot would
	// still read back with good parity, so the map is checked alone
	AST_MAP_S4_FINE: assert property (reg_rd && reg_addr == 6'h16 |-> mif.re && mif.raddr == 3'h0) // see (R1)
		else $error("stop-4 fine address decoded wrong");

	AST_MAP_S4_COARSE: assert property (reg_rd && reg_addr == 6'h17 |-> mif.re && mif.raddr == 3'h1) // see (R2)
		else $error("stop-4 coarse address decoded wrong");

	AST_MAP_S5_FINE: assert property (reg_rd && reg_addr == 6'h18 |-> mif.re && mif.raddr == 3'h2) // see (R3)
		else $error("stop-5 fine address decoded wrong");

	AST_MAP_S5_COARSE: assert property (reg_rd && reg_addr == 6'h19 |-> mif.re && mif.raddr == 3'h3) // see (R4)
		else $error("stop-5 coarse address decoded wrong");

	AST_MAP_S6_FINE: assert property (reg_rd && reg_addr == 6'h1A |-> mif.re && mif.raddr == 3'h4) // see (R5)
		else $error("stop-6 fine address decoded wrong");

	AST_MAP_MISS: assert property (reg_rd && (reg_addr < 6'h16 || reg_addr > 6'h1B) |-> !mif.re)
		else $error("unmapped address reached storage");

	////////////////////////////////////////////////////////////////////////////////
	// Load path: only a completed result for a real slot writes
	AST_LOAD_TAKEN: assert property (res_load && res_sel < 3'h6 |-> mif.we && mif.waddr == res_sel) // see (R10)
		else $error("completed result not stored");

	AST_SPARE_IGNORED: assert property (res_load && res_sel > 3'h5 |-> !mif.we)
		else $error("spare slot load reached storage");

	AST_NO_LOAD_NO_WRITE: assert property (!res_load |-> !mif.we) // see (R10)
		else $error("storage written without a completed result");

	AST_STORE_PARITY: assert property (mif.we |-> ^mif.wdata == 1'b0) // see (R9)
		else $error("stored word has odd parity");

	////////////////////////////////////////////////////////////////////////////////
	// Stored value against the raw result: fine slots and the
	// calibration keep all 23 bits, coarse slots at least the count
	AST_FINE_WHOLE: assert property (mif.we && mif.waddr != 3'h1 && mif.waddr != 3'h3 // see (R3), see (R6)
		|-> mif.wdata[22:0] == res_value)
		else $error("fine or calibration value not stored whole");

	AST_COARSE_COUNT: assert property (mif.we && (mif.waddr == 3'h1 || mif.waddr == 3'h3) // see (R2), see (R4)
		|-> mif.wdata[15:0] == res_value[15:0])
		else $error("coarse count bits not stored");

	AST_AVG_WHOLE: assert property (mif.we && avg_mode |-> mif.wdata[22:0] == res_value) // see (R7)
		else $error("averaging result lost extension bits");

	////////////////////////////////////////////////////////////////////////////////
	// Answer side: the word stands until the next answer, and each
	// valid pulse goes back to a read two edges earlier
	AST_RDATA_HOLD: assert property (!pend_reg |=> $stable(reg_rdata))
		else $error("read data changed without an answer");

	AST_RVALID_SOURCE: assert property (reg_rvalid |-> $past(reg_rd, 2))
		else $error("answer without a read two edges earlier");

	COV_LOAD_READ: cover property (res_load && res_sel == 3'h4 ##1 reg_rd && reg_addr == 6'h1A);
	COV_AVG_COARSE: cover property (res_load && res_sel == 3'h3 && avg_mode);
	COV_UNMAPPED: cover property (reg_rd && !rd_hit);
	COV_HOST_WRITE: cover property (reg_wr && reg_addr == 6'h17);
	COV_READ_LOAD_SAME: cover property (mif.re && mif.we && mif.raddr == mif.waddr);

endmodule : tofr_regs

// file: core/tofr_params.svh
`ifndef TOFR_PARAMS_SVH
`define TOFR_PARAMS_SVH

// Register addresses on the register port
`define TOFR_ADDR_S4_FINE   6'h16
`define TOFR_ADDR_S4_COARSE 6'h17
`define TOFR_ADDR_S5_FINE   6'h18
`define TOFR_ADDR_S5_COARSE 6'h19
`define TOFR_ADDR_S6_FINE   6'h1A
`define TOFR_ADDR_CAL1      6'h1B

// Storage slots inside the bank
`define TOFR_IDX_S4_FINE    3'h0
`define TOFR_IDX_S4_COARSE  3'h1
`define TOFR_IDX_S5_FINE    3'h2
`define TOFR_IDX_S5_COARSE  3'h3
`define TOFR_IDX_S6_FINE    3'h4
`define TOFR_IDX_CAL1       3'h5
`define TOFR_NUM_REGS       6

// Field layout
`define TOFR_PARITY_BIT     23
`define TOFR_VALUE_MSB      22
`define TOFR_EXT_MSB        22
`define TOFR_EXT_LSB        16
`define TOFR_EXT_ZERO       7'h00

// Reset values
`define TOFR_RESET_WORD     24'h000000

`endif

// file: core/tofr_pkg.sv
package tofr_pkg;

	// Slot number of a result register
	typedef logic [2:0]  tofr_idx_t;
	// Stored word: parity on top, value below
	typedef logic [23:0] tofr_word_t;
	typedef logic [22:0] tofr_value_t;

	// Kind of result held in a slot
	typedef enum logic {
		TOFR_FINE   = 1'b0,
		TOFR_COARSE = 1'b1
	} tofr_kind_e;

endpackage : tofr_pkg

// file: core/tofr_mem_if.sv
`timescale 1ns/1ps
interface tofr_mem_if;
	logic                  we;
	tofr_pkg::tofr_idx_t   waddr;
	tofr_pkg::tofr_word_t  wdata;
	logic                  re;
	tofr_pkg::tofr_idx_t   raddr;
	tofr_pkg::tofr_word_t  rdata;

	modport ctrl (output we, output waddr, output wdata, output re, output raddr, input rdata);
	modport store (input we, input waddr, input wdata, input re, input raddr, output rdata);
endinterface : tofr_mem_if

// file: core/tofr_mem.sv
`timescale 1ns/1ps
`include "tofr_params.svh"
module tofr_mem (
	input  wire logic     mclk,
	input  wire logic     rst,
	tofr_mem_if.store     mif
);

	tofr_pkg::tofr_word_t word_reg [`TOFR_NUM_REGS];
	tofr_pkg::tofr_word_t rdata_reg;

	////////////////////////////////////////////////////////////////////////////////
	// One flop word per slot, so reset clears everything at once
	genvar g;
	generate
		for (g = 0; g < `TOFR_NUM_REGS; g++) begin : g_slot
			always_ff @(posedge mclk or posedge rst) begin
				if (rst) begin
					word_reg[g] <= `TOFR_RESET_WORD; // see (R8)
				end else if (mif.we && (mif.waddr == 3'(g))) begin
					word_reg[g] <= mif.wdata; // see (R10)
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// Registered read; a slot past the last reads as zero
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rdata_reg <= `TOFR_RESET_WORD;
		end else if (mif.re) begin
			if (mif.raddr < 3'(`TOFR_NUM_REGS)) begin
				rdata_reg <= word_reg[mif.raddr];
			end else begin
				rdata_reg <= `TOFR_RESET_WORD;
			end
		end
	end

	assign mif.rdata = rdata_reg;

	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	AST_MEM_HOLD: assert property (!mif.we |=> $stable(word_reg[0]) && $stable(word_reg[5])) // see (R10)
		else $error("slot changed without a load");
	AST_MEM_READ: assert property (mif.re && !mif.we && mif.raddr == 3'h2 |=> rdata_reg == word_reg[2])
		else $error("read data does not match slot");

endmodule : tofr_mem

// file: tb/tofr_load_model.sv
`timescale 1ns/1ps
// Measurement engine stand-in that feeds completed results into the bank
module tofr_load_model (
	input  wire logic             mclk,
	output logic                  res_load,
	output tofr_pkg::tofr_idx_t   res_sel,
	output tofr_pkg::tofr_value_t res_value,
	output logic                  avg_mode
);
	// Idle bus never shows a stale result
	initial begin
		res_load = 1'b0;
		res_sel = 3'h7;
		res_value = 23'h2AAAAA;
		avg_mode = 1'b0;
	end
	// One-cycle completion pulse, then the value lines are scrambled
	task automatic push(input tofr_pkg::tofr_idx_t sel, input tofr_pkg::tofr_value_t v, input logic avg);
		@(negedge mclk);
		res_load = 1'b1;
		res_sel = sel;
		res_value = v;
		avg_mode = avg;
		@(negedge mclk);
		res_load = 1'b0;
		res_sel = ~sel;
		res_value = ~v;
		avg_mode = ~avg;
	endtask : push
endmodule : tofr_load_model

// file: tb/tof_result_readback_regs_test.sv
`timescale 1ns/1ps
module tof_result_readback_regs_test;
	logic                  mclk;
	logic                  rst;
	logic [5:0]            reg_addr;
	logic                  reg_rd;
	logic                  reg_wr;
	logic [23:0]           reg_rdata;
	logic                  reg_rvalid;
	logic                  res_load;
	tofr_pkg::tofr_idx_t   res_sel;
	tofr_pkg::tofr_value_t res_value;
	logic                  avg_mode;
	int                    miscompares;
	int                    n_compared;
	int                    cycles;
	logic [23:0]           exp_w [6];
	tofr_pkg::tofr_value_t vals [6] = '{23'h7FFFFF, 23'h7F1234, 23'h000001, 23'h55ABCD, 23'h400000, 23'h123456};

	tofr_regs dut (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
		.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .res_load(res_load), .res_sel(res_sel),
		.res_value(res_value), .avg_mode(avg_mode));
	tofr_load_model ld (.mclk(mclk), .res_load(res_load), .res_sel(res_sel), .res_value(res_value),
		.avg_mode(avg_mode));

	////////////////////////////////////////////////////////////////
	// Clock and hang guard; a whole run needs about 150 cycles
	always #2.5 mclk = ~mclk;
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 2000) begin
			miscompares++;
			final_report;
		end
	end

	////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// Expected word: coarse slots lose 22:16 unless averaging, even parity on top
	function automatic logic [23:0] exp_word(input int sel, input tofr_pkg::tofr_value_t v, input logic avg);
		tofr_pkg::tofr_value_t w;
		w = v;
		if ((sel == 1 || sel == 3) && !avg)
			w[22:16] = 7'h00;
		return {^w, w};
	endfunction : exp_word
	// Single read; answer lands two edges after the request is taken
	task automatic rd(input logic [5:0] a, input logic [23:0] exp);
		@(negedge mclk);
		reg_rd = 1'b1;
		reg_addr = a;
		@(negedge mclk);
		reg_rd = 1'b0;
		reg_addr = ~a;
		@(negedge mclk);
		check("rvalid", {23'h0, reg_rvalid}, 24'h000001);
		check("rdata", reg_rdata, exp);
	endtask : rd
	task automatic wr(input logic [5:0] a);
		@(negedge mclk);
		reg_wr = 1'b1;
		reg_addr = a;
		@(negedge mclk);
		reg_wr = 1'b0;
	endtask : wr
	task automatic final_report;
		$display("Compared %0d, mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : final_report

	////////////////////////////////////////////////////////////////
	initial begin
		mclk = 1'b0;
		rst = 1'b1;
		reg_addr = 6'h00;
		reg_rd = 1'b0;
		reg_wr = 1'b0;
		miscompares = 0;
		n_compared = 0;
		cycles = 0;
		repeat (8) @(posedge mclk);
		@(negedge mclk);
		rst = 1'b0;
		// Zero out of reset, unmapped place included
		for (int i = 0; i < 6; i++) rd(6'h16 + i[5:0], 24'h000000);
		rd(6'h15, 24'h000000);
		// Load every slot with averaging off
		for (int i = 0; i < 6; i++) begin
			ld.push(i[2:0], vals[i], 1'b0);
			exp_w[i] = exp_word(i, vals[i], 1'b0);
			rd(6'h16 + i[5:0], exp_w[i]);
		end
		// Unmapped places answer zero even with every slot loaded
		rd(6'h15, 24'h000000);
		rd(6'h1C, 24'h000000);
		// Host writes and a spare slot must leave results alone
		for (int i = 0; i < 6; i++) wr(6'h16 + i[5:0]);
		ld.push(3'h6, 23'h7FFFFF, 1'b0);
		for (int i = 0; i < 6; i++) rd(6'h16 + i[5:0], exp_w[i]);
		// Averaging keeps the extension bits of coarse counts
		ld.push(3'h1, vals[0], 1'b1);
		rd(6'h17, exp_word(1, vals[0], 1'b1));
		ld.push(3'h3, vals[1], 1'b1);
		rd(6'h19, exp_word(3, vals[1], 1'b1));
		// A read on the cycle right after a load sees the new word
		for (int i = 0; i < 6; i += 2) begin
			exp_w[i] = exp_word(i, vals[5 - i], 1'b0);
			fork
				ld.push(i[2:0], vals[5 - i], 1'b0);
				begin
					@(negedge mclk);
					rd(6'h16 + i[5:0], exp_w[i]);
				end
			join
		end
		// A read in the load's own cycle still sees the old word
		fork
			ld.push(3'h4, vals[0], 1'b0);
			rd(6'h1A, exp_w[4]);
		join
		exp_w[4] = exp_word(4, vals[0], 1'b0);
		rd(6'h1A, exp_w[4]);
		// Back-to-back reads answer on consecutive cycles
		@(negedge mclk);
		reg_rd = 1'b1;
		reg_addr = 6'h16;
		@(negedge mclk);
		reg_addr = 6'h1B;
		@(negedge mclk);
		reg_rd = 1'b0;
		check("pipe0", reg_rdata, exp_w[0]);
		@(negedge mclk);
		check("pipe1", reg_rdata, exp_w[5]);
		check("pipe1_valid", {23'h0, reg_rvalid}, 24'h000001);
		// Answer stands once the reads stop, valid does not
		@(negedge mclk);
		check("hold", reg_rdata, exp_w[5]);
		check("idle_valid", {23'h0, reg_rvalid}, 24'h000000);
		// Mid-run reset clears every word and the answer at once
		rst = 1'b1;
		@(negedge mclk);
		check("rst_rdata", reg_rdata, 24'h000000);
		rst = 1'b0;
		for (int i = 0; i < 6; i++) rd(6'h16 + i[5:0], 24'h000000);
		final_report;
	end
endmodule : tof_result_readback_regs_test
